//--- l2c_ctrl.sv
`timescale 1ns/1ps
module l2c_ctrl
  import l2c_pkg::*;
#(
  parameter int TAG_ENTRIES = L2C_TAG_ENTRIES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [9:0]  spr_num,
  input  wire logic        spr_wr,
  input  wire logic        spr_rd,
  input  wire logic [31:0] spr_wdata,
  output logic      [31:0] spr_rdata,
  output logic             spr_rd_valid,
  input  wire l2c_req_t    req,
  output l2c_dec_t         dec,
  input  wire logic        nap_mode,
  input  wire logic        sleep_mode,
  output logic             sram_sleep_out,
  output logic             tag_clr_valid,
  output logic      [$clog2(TAG_ENTRIES)-1:0] tag_clr_index,
  output l2c_phy_t         phy,
  output logic             sram_clock_out_a,
  output logic             sram_clock_out_b
);

  // ************************************************************
  // Derived sizes
  // ************************************************************
  // The sweep index is only as wide as the tag store needs, so a small tag count
  // gives a short sweep in simulation with the same logic as the full one.
  localparam int IW = $clog2(TAG_ENTRIES);
  localparam logic [IW-1:0] LAST_IDX = IW'(TAG_ENTRIES - 1);

  // ************************************************************
  // Control register
  // ************************************************************
  logic [30:0] ctrl_r;
  logic [30:0] ctrl_nxt;
  logic        ip_r;
  logic        ip_nxt;
  logic [IW-1:0] idx_r;
  logic [IW-1:0] idx_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        rdv_r;
  logic        rdv_nxt;
  logic        wr_hit;
  logic        inval_start;

  // Only this register number is decoded; an invalidate request that lands while a
  // sweep already runs is stored but does not count as a new start.
  assign wr_hit      = spr_wr && (spr_num == L2C_SPR_NUM);
  assign inval_start = wr_hit && spr_wdata[L2C_INVAL_BIT] && !ip_r;

  // Bits 0 to 30 store what software writes, spare bits included; bit 31 is never stored.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_hit) begin
      ctrl_nxt = spr_wdata[30:0];
    end
  end

  // The sweep walks one tag entry per cycle; a second invalidate request during a sweep
  // is ignored rather than restarting it, so the flag always falls on a full pass.
  always_comb begin
    ip_nxt  = ip_r;
    idx_nxt = idx_r;
    if (inval_start) begin
      ip_nxt  = 1'b1;
      idx_nxt = '0;
    end else if (ip_r) begin
      if (idx_r == LAST_IDX) begin
        ip_nxt  = 1'b0;
        idx_nxt = '0;
      end else begin
        idx_nxt = idx_r + IW'(1);
      end
    end
  end

  // Reads answer one cycle later; other register numbers belong to neighbours and get no answer.
  always_comb begin
    rdata_nxt = rdata_r;
    rdv_nxt   = 1'b0;
    if (spr_rd && (spr_num == L2C_SPR_NUM)) begin
      rdata_nxt = {ip_r, ctrl_r};
      rdv_nxt   = 1'b1;
    end
  end

  // Register stage for the control word, the sweep and the read answer. Reset is
  // synchronous, so the register is cleared only on a clock edge with reset low.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r  <= L2C_CTRL_RESET[30:0];
      ip_r    <= 1'b0;
      idx_r   <= '0;
      rdata_r <= L2C_CTRL_RESET;
      rdv_r   <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      ip_r    <= ip_nxt;
      idx_r   <= idx_nxt;
      rdata_r <= rdata_nxt;
      rdv_r   <= rdv_nxt;
    end
  end

  // The tag clear strobe is the in-progress flag itself, so the tag array is swept in
  // exactly the cycles in which software reads bit 31 as set. The index is registered,
  // which keeps the long tag address lines off any combinational path.
  assign spr_rdata     = rdata_r;
  assign spr_rd_valid  = rdv_r;
  assign tag_clr_valid = ip_r;
  assign tag_clr_index = idx_r;

  // ************************************************************
  // Transaction steering
  // ************************************************************
  logic     en;
  logic     data_only;
  logic     wt;
  logic     ts;
  l2c_dec_t dec_r;
  l2c_dec_t dec_nxt;

  // Mode bits are read straight from the stored word; none of them needs a copy of its
  // own, since every decision below is registered once more on its way out.
  assign en        = ctrl_r[L2C_ENABLE_BIT];
  assign data_only = ctrl_r[L2C_DATA_ONLY_BIT];
  assign wt        = ctrl_r[L2C_WT_BIT];
  assign ts        = ctrl_r[L2C_TS_BIT];

  // The register value at the moment a request arrives decides it, so a write to the
  // enable bit first affects the request after the write. A sweep in progress also
  // forces bypass, since the tags are not trustworthy until it ends.
  always_comb begin
    dec_nxt       = '0;
    dec_nxt.valid = req.valid;
    if (req.valid) begin
      if (!en || ip_r || (data_only && req.from_icache)) begin
        dec_nxt.bypass    = 1'b1;
        dec_nxt.bus_xfer  = !req.is_zero_block;
        dec_nxt.broadcast = req.is_zero_block && !ts;
      end else if (req.is_push) begin
        if (ts) begin
          dec_nxt.l2_write   = 1'b1;
          dec_nxt.mark_clean = 1'b1;
        end else begin
          dec_nxt.bus_xfer       = 1'b1;
          dec_nxt.invalidate_hit = 1'b1;
        end
      end else if (req.is_zero_block) begin
        dec_nxt.l2_lookup = 1'b1;
        dec_nxt.broadcast = !ts;
      end else if (req.is_write) begin
        dec_nxt.l2_write      = 1'b1;
        dec_nxt.mark_clean    = wt;
        dec_nxt.mark_modified = !wt;
        dec_nxt.bus_xfer      = wt || (req.single_beat_miss && !ts);
        // Test support outranks write-through for a single-beat store miss.
        if (req.single_beat_miss && ts) begin
          dec_nxt.bus_xfer = 1'b0;
        end
      end else begin
        dec_nxt.l2_lookup = 1'b1;
      end
    end
  end

  // The decision is registered, so every request is answered exactly one cycle later
  // and the answer holds for that one cycle only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dec_r <= '0;
    end else begin
      dec_r <= dec_nxt;
    end
  end

  // Decision out to the cache datapath.
  assign dec = dec_r;

  // ************************************************************
  // Low power, physical options and SRAM clock
  // ************************************************************
  logic     sleep_r;
  logic     sleep_nxt;
  l2c_phy_t phy_r;
  l2c_phy_t phy_nxt;

  // Sleep follows the power modes only while automatic control is on.
  always_comb begin
    sleep_nxt = ctrl_r[L2C_LOWPWR_BIT] && (nap_mode || sleep_mode);
  end

  // Reserved hold codes fall back to the short hold, the safer choice for timing closure.
  always_comb begin
    phy_nxt.dll_slow         = ctrl_r[L2C_DLL_SLOW_BIT];
    phy_nxt.dll_bypass       = ctrl_r[L2C_DLL_BYP_BIT];
    phy_nxt.output_hold_sel  = ctrl_r[L2C_HOLD_MSB:L2C_HOLD_LSB];
    phy_nxt.hold_long        = (ctrl_r[L2C_HOLD_MSB:L2C_HOLD_LSB] == L2C_HOLD_1P0NS);
    phy_nxt.sram_clock_ratio = ctrl_r[L2C_RATIO_MSB:L2C_RATIO_LSB];
  end

  // Sleep and the physical options leave through flip-flops so that the pads see no
  // glitch while software rewrites the register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_r <= 1'b0;
      phy_r   <= '0;
    end else begin
      sleep_r <= sleep_nxt;
      phy_r   <= phy_nxt;
    end
  end

  // Registered low-power and physical option outputs.
  assign sram_sleep_out = sleep_r;
  assign phy            = phy_r;

  // ************************************************************
  // SRAM clock outputs
  // ************************************************************
  // Cycle-level model of the SRAM clock: a phase accumulator adds two each core cycle and
  // toggles the output each time it passes twice the divide ratio. This gives the right
  // average edge rate for the half-step ratios, at the cost of uneven edge spacing.
  logic [3:0] step;
  logic [3:0] acc_r;
  logic [3:0] acc_nxt;
  logic       ca_r;
  logic       ca_nxt;
  logic       cb_r;
  logic       cb_nxt;

  // Twice the divide ratio; the reserved and off codes give zero, which stops A low (B high with
  // the differential bit set) rather than running the clock at a rate the SRAMs were never set up for.
  always_comb begin
    case (ctrl_r[L2C_RATIO_MSB:L2C_RATIO_LSB])
      L2C_RATIO_DIV1:   step = 4'h2;
      L2C_RATIO_DIV1P5: step = 4'h3;
      L2C_RATIO_DIV2:   step = 4'h4;
      L2C_RATIO_DIV2P5: step = 4'h5;
      L2C_RATIO_DIV3:   step = 4'h6;
      default:          step = 4'h0;
    endcase
  end

  always_comb begin
    acc_nxt = acc_r;
    ca_nxt  = ca_r;
    if (step == 4'h0) begin
      acc_nxt = 4'h0;
      ca_nxt  = 1'b0;
    end else if ((acc_r + 4'h2) >= step) begin
      acc_nxt = acc_r + 4'h2 - step;
      ca_nxt  = !ca_r;
    end else begin
      acc_nxt = acc_r + 4'h2;
    end
    cb_nxt = ctrl_r[L2C_DIFF_CLK_BIT] ? !ca_nxt : ca_nxt;
  end

  // Both clock outputs come from flip-flops, so B (the complement of A with the differential bit set, a copy of A otherwise)
  // changes in the same cycle as A and never lags it by a gate delay.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_r <= 4'h0;
      ca_r  <= 1'b0;
      cb_r  <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      ca_r  <= ca_nxt;
      cb_r  <= cb_nxt;
    end
  end

  // Clock pair to the pads. A limitation: edges move on core clock edges only, so the
  // half-step ratios carry one core cycle of jitter.
  assign sram_clock_out_a = ca_r;
  assign sram_clock_out_b = cb_r;

endmodule

//--- l2c_ctrl_asserts.sv
`timescale 1ns/1ps
// ****
// Checker
// ****
module l2c_ctrl_asserts
  import l2c_pkg::*;
#(
  parameter int TAG_ENTRIES = L2C_TAG_ENTRIES
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [9:0]  spr_num,
  input wire logic        spr_wr,
  input wire logic        spr_rd,
  input wire logic [31:0] spr_wdata,
  input wire logic [31:0] spr_rdata,
  input wire logic        spr_rd_valid,
  input wire l2c_req_t    req,
  input wire l2c_dec_t    dec,
  input wire logic        nap_mode,
  input wire logic        sleep_mode,
  input wire logic        sram_sleep_out,
  input wire logic        tag_clr_valid,
  input wire logic [$clog2(TAG_ENTRIES)-1:0] tag_clr_index,
  input wire l2c_phy_t    phy,
  input wire logic        sram_clock_out_a,
  input wire logic        sram_clock_out_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] ctl_r;
  logic        hit;
  // Shadow of the register, so each field effect is tied to what software wrote.
  always_ff @(posedge clk) begin
    if (!rst_n) ctl_r <= '0;
    else if (spr_wr && spr_num == L2C_SPR_NUM) ctl_r <= spr_wdata;
  end
  // A request that reaches the cache instead of bypassing it.
  assign hit = req.valid && ctl_r[0] && !tag_clr_valid && !(ctl_r[9] && req.from_icache);
  a_rd_answer: assert property (
    spr_rd_valid == $past(spr_rd && spr_num == L2C_SPR_NUM))
    else $error("read answer timing wrong");
  a_rd_data: assert property (
    spr_rd_valid |-> spr_rdata == {$past(tag_clr_valid), $past(ctl_r[30:0])})
    else $error("read data wrong");
  a_sleep_follow: assert property (
    sram_sleep_out == $past(ctl_r[11] && (nap_mode || sleep_mode)))
    else $error("sram sleep wrong");
  a_phy_copy: assert property ($stable(ctl_r) |->
    phy == {ctl_r[16], ctl_r[18], ctl_r[15:14] == L2C_HOLD_1P0NS, ctl_r[15:14], ctl_r[6:4]})
    else $error("phy settings wrong");
  a_clock_pair: assert property (
    $stable(ctl_r[17:4]) && ctl_r[6:4] == L2C_RATIO_DIV1 |->
    sram_clock_out_b == (sram_clock_out_a ^ ctl_r[17])) else $error("clock pair wrong");
  a_sweep_step: assert property (
    tag_clr_valid && tag_clr_index != TAG_ENTRIES - 1 |=>
    tag_clr_valid && tag_clr_index == $past(tag_clr_index) + 1'b1)
    else $error("sweep step wrong");
  // Test support outranks write-through for a single-beat store miss.
  a_write_thru: assert property (hit && !req.is_push && !req.is_zero_block &&
    req.is_write && ctl_r[12] |=> dec.l2_write && dec.mark_clean && !dec.mark_modified &&
    dec.bus_xfer == !$past(req.single_beat_miss && ctl_r[13]))
    else $error("write-through wrong");
  a_push_ts: assert property (hit && req.is_push && ctl_r[13] |=>
    dec.l2_write && dec.mark_clean && !dec.bus_xfer && !dec.invalidate_hit)
    else $error("test push wrong");
  a_data_only: assert property (req.valid && ctl_r[9] && req.from_icache |=> dec.bypass)
    else $error("data-only bypass wrong");
endmodule

bind l2c_ctrl l2c_ctrl_asserts #(.TAG_ENTRIES(TAG_ENTRIES)) u_chk (
  .clk(clk), .rst_n(rst_n), .spr_num(spr_num), .spr_wr(spr_wr), .spr_rd(spr_rd),
  .spr_wdata(spr_wdata), .spr_rdata(spr_rdata), .spr_rd_valid(spr_rd_valid), .req(req), .dec(dec),
  .nap_mode(nap_mode), .sleep_mode(sleep_mode), .sram_sleep_out(sram_sleep_out),
  .tag_clr_valid(tag_clr_valid), .tag_clr_index(tag_clr_index), .phy(phy),
  .sram_clock_out_a(sram_clock_out_a), .sram_clock_out_b(sram_clock_out_b)
);

//--- l2c_ctrl_bench.sv
`timescale 1ns/1ps
// ****
// Bench
// ****
module l2c_ctrl_bench
  import l2c_pkg::*;
;
  localparam int TE = 8;
  logic        clk, rst_n, spr_wr, spr_rd, nap_mode, sleep_mode, spr_rd_valid;
  logic        sram_sleep_out, tag_clr_valid, ck_a, ck_b;
  logic [9:0]  spr_num;
  logic [31:0] spr_wdata, spr_rdata, v;
  logic [2:0]  tag_clr_index;
  l2c_req_t    req, r;
  l2c_dec_t    dec;
  l2c_phy_t    phy;
  int          miscompares, comparisons, seed, clk_edges, ipc;
  logic [31:0] rq_q[$];
  l2c_dec_t    dq[$];
  l2c_ctrl #(.TAG_ENTRIES(TE)) dut (
    .clk(clk), .rst_n(rst_n), .spr_num(spr_num), .spr_wr(spr_wr), .spr_rd(spr_rd),
    .spr_wdata(spr_wdata), .spr_rdata(spr_rdata), .spr_rd_valid(spr_rd_valid), .req(req),
    .dec(dec), .nap_mode(nap_mode), .sleep_mode(sleep_mode), .sram_sleep_out(sram_sleep_out),
    .tag_clr_valid(tag_clr_valid), .tag_clr_index(tag_clr_index), .phy(phy),
    .sram_clock_out_a(ck_a), .sram_clock_out_b(ck_b));
  l2c_sram_model sram (.rst_n(rst_n), .sram_clock_out_a(ck_a), .sram_sleep_out(sram_sleep_out),
    .clk_edges(clk_edges));
  // Core clock, 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [31:0] d, input logic [9:0] n);
    spr_wr = 1'b1; spr_num = n; spr_wdata = d;
    cyc;
    spr_wr = 1'b0;
    cyc;
  endtask
  // Only the control register answers, so only its reads leave a note.
  task automatic rd(input logic [9:0] n, input logic [31:0] e);
    if (n == L2C_SPR_NUM) rq_q.push_back(e);
    spr_rd = 1'b1; spr_num = n;
    cyc;
    spr_rd = 1'b0;
    cyc;
  endtask
  // Holds the request for one edge and notes the decision the modes call for.
  task automatic rq(input l2c_req_t q, input logic [31:0] c);
    l2c_dec_t d;
    d = '0;
    d.valid = 1'b1;
    if (!c[0] || (c[9] && q.from_icache)) begin
      d.bypass = 1'b1;
      d.bus_xfer = !q.is_zero_block;
      d.broadcast = q.is_zero_block && !c[13];
    end else if (q.is_push) begin
      {d.l2_write, d.mark_clean, d.bus_xfer, d.invalidate_hit} = c[13] ? 4'hc : 4'h3;
    end else if (q.is_zero_block) begin
      d.l2_lookup = 1'b1;
      d.broadcast = !c[13];
    end else if (q.is_write) begin
      d.l2_write = 1'b1;
      {d.mark_clean, d.mark_modified} = c[12] ? 2'h2 : 2'h1;
      d.bus_xfer = q.single_beat_miss ? !c[13] : c[12];
    end else d.l2_lookup = 1'b1;
    dq.push_back(d);
    req = q;
    cyc;
  endtask
  // An answer takes the oldest note; an answer with nothing pending is itself a fault.
  always @(negedge clk) begin
    if (tag_clr_valid === 1'b1) ipc++;
    if (spr_rd_valid === 1'b1) begin
      chk(spr_rdata, rq_q.size() ? rq_q.pop_front() : '1, "rdata");
    end
    if (dec.valid === 1'b1) begin
      chk(dec, dq.size() ? dq.pop_front() : '1, "dec");
    end
  end
  // Roughly 300 cycles of work; the margin covers a stuck sweep.
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    test_done;
  end
  initial begin
    seed = 59355;
    rst_n = 1'b0; spr_wr = 1'b0; spr_rd = 1'b0; spr_num = '0; spr_wdata = '0;
    req = '0; nap_mode = 1'b0; sleep_mode = 1'b0; miscompares = 0; comparisons = 0; ipc = 0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    rd(L2C_SPR_NUM, 32'h0);
    wr(32'h0000_ffff, L2C_SPR_NUM - 10'h1);
    rd(L2C_SPR_NUM + 10'h1, 32'h0);
    rd(L2C_SPR_NUM, 32'h0);
    chk(clk_edges, 0, "edges off");
    // DLL bypass is only ever set together with divide-by-one, as software must.
    v = ($random(seed) & 32'h7ff8_0000) | 32'h8007_4810;
    wr(v, L2C_SPR_NUM);
    rd(L2C_SPR_NUM, v & 32'h7fff_ffff);
    chk(phy, 8'he9, "phy");
    chk(ck_b, !ck_a, "clock pair");
    v[31] = ck_a;
    cyc;
    chk(ck_a, !v[31], "ratio one");
    // No snooping runs while napping here, so low power may stay set.
    for (int i = 1; i < 4; i++) begin
      {sleep_mode, nap_mode} = 2'(i % 3);
      cyc;
      cyc;
      chk(sram_sleep_out, i < 3, "sleep");
    end
    chk(clk_edges > 0, 1, "edges on");
    // The cache stays disabled while the invalidate is written.
    wr(32'h0000_0400, L2C_SPR_NUM);
    rd(L2C_SPR_NUM, 32'h8000_0400);
    for (int i = 0; i < 40 && tag_clr_valid !== 1'b0; i++) cyc;
    rd(L2C_SPR_NUM, 32'h0000_0400);
    chk(ipc, TE, "sweep length");
    // Modes change only with the cache disabled first, as software must.
    for (int m = 0; m < 16; m++) begin
      v = {18'h0, m[2], m[1], 2'h0, m[0], 8'h0, m[3]};
      wr(32'h0, L2C_SPR_NUM);
      wr(v, L2C_SPR_NUM);
      for (int k = 0; k < 12; k++) begin
        r = l2c_req_t'(6'($random(seed)));
        r.valid = 1'b1;
        rq(r, v);
      end
      req = '0;
      cyc;
    end
    cyc;
    chk(rq_q.size() + dq.size(), 0, "pending");
    test_done;
  end
endmodule

//--- l2c_pkg.sv
package l2c_pkg;

  // ************************************************************
  // Register number and field positions
  // ************************************************************
  localparam logic [9:0]  L2C_SPR_NUM        = 10'h3f9;
  localparam int          L2C_ENABLE_BIT     = 0;
  localparam int          L2C_RATIO_LSB      = 4;
  localparam int          L2C_RATIO_MSB      = 6;
  localparam int          L2C_DATA_ONLY_BIT  = 9;
  localparam int          L2C_INVAL_BIT      = 10;
  localparam int          L2C_LOWPWR_BIT     = 11;
  localparam int          L2C_WT_BIT         = 12;
  localparam int          L2C_TS_BIT         = 13;
  localparam int          L2C_HOLD_LSB       = 14;
  localparam int          L2C_HOLD_MSB       = 15;
  localparam int          L2C_DLL_SLOW_BIT   = 16;
  localparam int          L2C_DIFF_CLK_BIT   = 17;
  localparam int          L2C_DLL_BYP_BIT    = 18;
  localparam int          L2C_SPARE_LSB      = 19;
  localparam int          L2C_SPARE_MSB      = 30;
  localparam int          L2C_IP_BIT         = 31;
  localparam logic [31:0] L2C_CTRL_RESET     = 32'h0000_0000;

  // ************************************************************
  // Field encodings
  // ************************************************************
  localparam logic [1:0]  L2C_HOLD_0P5NS     = 2'h0;
  localparam logic [1:0]  L2C_HOLD_1P0NS     = 2'h1;
  localparam logic [2:0]  L2C_RATIO_OFF      = 3'h0;
  localparam logic [2:0]  L2C_RATIO_DIV1     = 3'h1;
  localparam logic [2:0]  L2C_RATIO_DIV1P5   = 3'h2;
  localparam logic [2:0]  L2C_RATIO_DIV2     = 3'h4;
  localparam logic [2:0]  L2C_RATIO_DIV2P5   = 3'h5;
  localparam logic [2:0]  L2C_RATIO_DIV3     = 3'h6;
  localparam int          L2C_TAG_ENTRIES    = 4096;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic from_icache;
    logic is_write;
    logic is_push;
    logic is_zero_block;
    logic single_beat_miss;
  } l2c_req_t;

  typedef struct packed {
    logic valid;
    logic bypass;
    logic l2_lookup;
    logic l2_write;
    logic mark_modified;
    logic mark_clean;
    logic invalidate_hit;
    logic bus_xfer;
    logic broadcast;
  } l2c_dec_t;

  typedef struct packed {
    logic       dll_slow;
    logic       dll_bypass;
    logic       hold_long;
    logic [1:0] output_hold_sel;
    logic [2:0] sram_clock_ratio;
  } l2c_phy_t;

endpackage

//--- l2c_sram_model.sv
`timescale 1ns/1ps
// ****
// SRAM clock sink
// ****
module l2c_sram_model (
  input  wire logic rst_n,
  input  wire logic sram_clock_out_a,
  input  wire logic sram_sleep_out,
  output int        clk_edges
);
  // A sleeping SRAM ignores its clock, so only edges seen while awake count.
  always @(posedge sram_clock_out_a or negedge rst_n) begin
    if (!rst_n) clk_edges <= 0;
    else if (!sram_sleep_out) clk_edges <= clk_edges + 1;
  end
endmodule
